//--- core/serial_regs_cfg.svh
// Register offsets, field positions and reset values of the serial register block.
`ifndef SERIAL_REGS_CFG_SVH
`define SERIAL_REGS_CFG_SVH
`define OFS_CONTROL_ONE       8'h00
`define OFS_CONTROL_TWO       8'h04
`define OFS_CONTROL_THREE     8'h08
`define OFS_BAUD_DIVISOR      8'h0C
`define OFS_REQUEST_TRIGGER   8'h18
`define OFS_STATUS_FLAGS      8'h1C
`define OFS_FLAG_CLEAR        8'h20
`define OFS_RECEIVE_HOLDING   8'h24
`define OFS_TRANSMIT_HOLDING  8'h28
`define OFS_CLOCK_DIV_SELECT  8'h2C
`define BIT_TRANSCEIVER_EN    0
`define BIT_PARITY_ODD        9
`define BIT_PARITY_ENABLE     10
`define BIT_WORD_LEN0         12
`define BIT_WORD_LEN1         28
`define BIT_FLAG_TC           6
`define BIT_FLAG_TXE          7
`define BIT_FLAG_RXNE         5
`define BIT_FLAG_PE           0
`define RESET_WORD            32'h0000_0000
`define RESET_PRESC           4'h0
`define PRESC_MAX_CODE        4'hB
`define BAUD_MASK             32'h000F_FFFF
`define DIV_COUNT_W           8
`endif

//--- core/serial_regs_pkg.sv
// Types shared by the serial register block.
`default_nettype none
package serial_regs_pkg;
	typedef logic [3:0] presc_code_t;
	typedef logic [8:0] char_t;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01
	} tx_state_t;
endpackage
`default_nettype wire

//--- core/kernel_prescaler.sv
// Kernel clock prescaler producing a one-cycle enable at the selected rate.
`include "serial_regs_cfg.svh"
`default_nettype none
module kernel_prescaler
	import serial_regs_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire serial_regs_pkg::presc_code_t code_i,
	output logic                        tick_o
);
	logic [`DIV_COUNT_W-1:0] count_reg;
	logic [8:0]              ratio;

	function automatic logic [8:0] ratio_of(input presc_code_t c);
		case (c)
			4'h0: ratio_of = 9'h001;
			4'h1: ratio_of = 9'h002;
			4'h2: ratio_of = 9'h004;
			4'h3: ratio_of = 9'h006;
			4'h4: ratio_of = 9'h008;
			4'h5: ratio_of = 9'h00A;
			4'h7: ratio_of = 9'h010;
			4'h8: ratio_of = 9'h020;
			4'h9: ratio_of = 9'h040;
			4'hA: ratio_of = 9'h080;
			default: ratio_of = 9'h100;
		endcase
	endfunction

	assign ratio = ratio_of(code_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= '0;
			tick_o    <= 1'b0;
		end else if ({1'b0, count_reg} >= ratio - 9'h001) begin
			count_reg <= '0;
			tick_o    <= 1'b1;
		end else begin
			count_reg <= count_reg + 8'h01;
			tick_o    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- core/serial_regs.sv
// Register file and transmit path of the low-power serial transceiver.
// Function
// - Nine-bit transmit character feeds shift register.
// - Parity replaces top data bit when enabled.
// - Prescaler codes select listed divide ratios.
// - Reserved prescaler codes divide by 256.
// - Prescaler at 0x2C, four bits, resets zero.
// - Received parity bit returned in top bit.
// - Writing one to clear register clears flag.
//
// Local design decision: register access over Wishbone.
`include "serial_regs_cfg.svh"
`default_nettype none
module serial_regs
	import serial_regs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	input  wire logic        rx_char_valid_i,
	input  wire logic [8:0]  rx_char_i,
	input  wire logic        rx_parity_err_i,
	output logic             tx_line_o,
	output logic             divided_tick_o
);
	import serial_regs_pkg::*;

	logic [31:0] control_one_reg;
	logic [31:0] control_two_reg;
	logic [31:0] control_three_reg;
	logic [31:0] baud_divisor_reg;
	presc_code_t presc_reg;
	char_t       transmit_char_field_reg;
	char_t       receive_char_field_reg;
	logic        transmit_empty_flag_reg;
	logic        transmission_complete_flag_reg;
	logic        rx_not_empty_reg;
	logic        parity_err_reg;
	tx_state_t   tx_state_reg;
	logic [10:0] shift_reg;
	logic [3:0]  bits_left_reg;
	logic [19:0] baud_count_reg;
	logic        tick;
	logic        wr;
	logic        rd;
	logic        hit;
	logic        transceiver_enable;
	logic        parity_enable;
	logic        nine_bit;
	logic        baud_tick;
	logic [31:0] rdata_next;
	logic [31:0] status_word;
	char_t       tx_char;
	logic        tx_hold_wr;
	logic        frame_end;
	logic        clear_tc;
	logic        clear_pe;
	logic        load_now;
	logic        presc_wr;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// Strobe for a write to one offset with byte lane zero enabled.
	function automatic logic lane0_write(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [7:0] ofs);
		lane0_write = w && s[0] && (a == ofs);
	endfunction

	// Even or odd parity over the data bits below the parity position.
	function automatic logic parity_of(input logic [7:0] d, input logic odd);
		parity_of = ^d ^ odd;
	endfunction

	assign wr = cyc_i & stb_i & we_i & ~ack_o & ~err_o;
	assign rd = cyc_i & stb_i & ~we_i & ~ack_o & ~err_o;
	assign transceiver_enable = control_one_reg[`BIT_TRANSCEIVER_EN];
	assign parity_enable = control_one_reg[`BIT_PARITY_ENABLE];
	assign nine_bit = control_one_reg[`BIT_WORD_LEN0] & ~control_one_reg[`BIT_WORD_LEN1];
	assign tx_hold_wr = wr && adr_i == `OFS_TRANSMIT_HOLDING;
	// Last stop bit leaves the shift register on this baud tick.
	assign frame_end = tx_state_reg == TX_SHIFT && baud_tick && bits_left_reg == 4'h1;
	assign load_now = tx_state_reg == TX_IDLE && transceiver_enable && baud_tick;
	assign clear_tc = lane0_write(wr, adr_i, sel_i, `OFS_FLAG_CLEAR) && dat_i[`BIT_FLAG_TC];
	assign clear_pe = lane0_write(wr, adr_i, sel_i, `OFS_FLAG_CLEAR) && dat_i[`BIT_FLAG_PE];
	assign presc_wr = lane0_write(wr, adr_i, sel_i, `OFS_CLOCK_DIV_SELECT)
		&& !transceiver_enable;

	always_comb begin
		hit = 1'b1;
		case (adr_i)
			`OFS_CONTROL_ONE, `OFS_CONTROL_TWO, `OFS_CONTROL_THREE, `OFS_BAUD_DIVISOR,
			`OFS_REQUEST_TRIGGER, `OFS_STATUS_FLAGS, `OFS_FLAG_CLEAR,
			`OFS_RECEIVE_HOLDING, `OFS_TRANSMIT_HOLDING, `OFS_CLOCK_DIV_SELECT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			ack_o <= (wr | rd) & hit;
			err_o <= (wr | rd) & ~hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_one_reg   <= `RESET_WORD;
			control_two_reg   <= `RESET_WORD;
			control_three_reg <= `RESET_WORD;
			baud_divisor_reg  <= `RESET_WORD;
		end else if (wr) begin
			case (adr_i)
				`OFS_CONTROL_ONE: control_one_reg <= merge(control_one_reg, dat_i, sel_i);
				`OFS_CONTROL_TWO: control_two_reg <= merge(control_two_reg, dat_i, sel_i);
				`OFS_CONTROL_THREE:
					control_three_reg <= merge(control_three_reg, dat_i, sel_i);
				`OFS_BAUD_DIVISOR:
					baud_divisor_reg <= merge(baud_divisor_reg, dat_i, sel_i) & `BAUD_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_reg <= `RESET_PRESC;
		end else if (presc_wr) begin
			presc_reg <= dat_i[3:0];
		end
	end

	kernel_prescaler u_presc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.code_i (presc_reg),
		.tick_o (tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			divided_tick_o <= 1'b0;
		end else begin
			divided_tick_o <= tick;
		end
	end

	// Baud tick from the divided kernel clock.
	always_ff @(posedge clk_i) begin
		if (rst_i || !transceiver_enable) begin
			baud_count_reg <= '0;
		end else if (tick) begin
			baud_count_reg <= (baud_count_reg >= baud_divisor_reg[19:0]) ? 20'h0_0000
				: baud_count_reg + 20'h0_0001;
		end
	end
	assign baud_tick = tick && (baud_count_reg >= baud_divisor_reg[19:0]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			transmit_char_field_reg <= '0;
		end else if (tx_hold_wr) begin
			transmit_char_field_reg <= char_t'(merge({23'h0, transmit_char_field_reg},
				dat_i, sel_i) & 32'h0000_01FF);
		end
	end

	always_comb begin
		tx_char = transmit_char_field_reg;
		if (parity_enable) begin
			if (nine_bit) begin
				tx_char[8] = parity_of(transmit_char_field_reg[7:0],
					control_one_reg[`BIT_PARITY_ODD]);
			end else begin
				tx_char[7] = parity_of({1'b0, transmit_char_field_reg[6:0]},
					control_one_reg[`BIT_PARITY_ODD]);
				tx_char[8] = 1'b0;
			end
		end else if (!nine_bit) begin
			tx_char[8] = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_reg  <= TX_IDLE;
			shift_reg     <= 11'h7FF;
			bits_left_reg <= 4'h0;
			tx_line_o     <= 1'b1;
		end else begin
			case (tx_state_reg)
				TX_IDLE: begin
					tx_line_o <= 1'b1;
					if (transceiver_enable && !transmit_empty_flag_reg && baud_tick) begin
						shift_reg     <= nine_bit ? {1'b1, tx_char, 1'b0}
							: {2'b11, tx_char[7:0], 1'b0};
						bits_left_reg <= nine_bit ? 4'hB : 4'hA;
						tx_state_reg  <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (baud_tick) begin
						tx_line_o     <= shift_reg[0];
						shift_reg     <= {1'b1, shift_reg[10:1]};
						bits_left_reg <= bits_left_reg - 4'h1;
						if (bits_left_reg == 4'h1) begin
							tx_state_reg <= TX_IDLE;
						end
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			transmit_empty_flag_reg <= 1'b1;
		end else if (tx_hold_wr) begin
			transmit_empty_flag_reg <= 1'b0;
		end else if (load_now) begin
			transmit_empty_flag_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			transmission_complete_flag_reg <= 1'b0;
			parity_err_reg                 <= 1'b0;
		end else begin
			if (frame_end && transmit_empty_flag_reg) begin
				transmission_complete_flag_reg <= 1'b1;
			end else if (clear_tc) begin
				transmission_complete_flag_reg <= 1'b0;
			end
			if (rx_char_valid_i && rx_parity_err_i) begin
				parity_err_reg <= 1'b1;
			end else if (clear_pe) begin
				parity_err_reg <= 1'b0;
			end
		end
	end

	// Received parity kept in top bit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			receive_char_field_reg <= '0;
			rx_not_empty_reg       <= 1'b0;
		end else if (rx_char_valid_i) begin
			receive_char_field_reg <= nine_bit ? rx_char_i : {1'b0, rx_char_i[7:0]};
			rx_not_empty_reg       <= 1'b1;
		end else if (rd && adr_i == `OFS_RECEIVE_HOLDING) begin
			rx_not_empty_reg <= 1'b0;
		end
	end

	always_comb begin
		status_word = `RESET_WORD;
		status_word[`BIT_FLAG_TXE]  = transmit_empty_flag_reg;
		status_word[`BIT_FLAG_TC]   = transmission_complete_flag_reg;
		status_word[`BIT_FLAG_RXNE] = rx_not_empty_reg;
		status_word[`BIT_FLAG_PE]   = parity_err_reg;
		case (adr_i)
			`OFS_CONTROL_ONE:      rdata_next = control_one_reg;
			`OFS_CONTROL_TWO:      rdata_next = control_two_reg;
			`OFS_CONTROL_THREE:    rdata_next = control_three_reg;
			`OFS_BAUD_DIVISOR:     rdata_next = baud_divisor_reg;
			`OFS_STATUS_FLAGS:     rdata_next = status_word;
			`OFS_RECEIVE_HOLDING:  rdata_next = {23'h0, receive_char_field_reg};
			`OFS_TRANSMIT_HOLDING: rdata_next = {23'h0, transmit_char_field_reg};
			`OFS_CLOCK_DIV_SELECT: rdata_next = {28'h0, presc_reg};
			default:               rdata_next = `RESET_WORD;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= `RESET_WORD;
		end else if (rd) begin
			dat_o <= rdata_next;
		end
	end
endmodule
`default_nettype wire

//--- dv/serial_regs_checker.sv
// Bus, readback, prescaler and line checks for the serial register block.
`include "serial_regs_cfg.svh"
`default_nettype none
module serial_regs_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic        rx_char_valid_i,
	input wire logic [8:0]  rx_char_i,
	input wire logic        tx_line_o,
	input wire logic        divided_tick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       tk, rd, map, en, seen, wl0, wl1;
	logic [3:0] pexp;
	logic [8:0] lrx, gap;
	assign tk = cyc_i && stb_i && !ack_o && !err_o;
	assign rd = ack_o && !we_i;
	assign map = adr_i[1:0] == 2'b00 && adr_i <= 8'h2C && !(adr_i inside {8'h10, 8'h14});
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en <= 1'b0;
			pexp <= `RESET_PRESC;
		end else if (tk && we_i && sel_i[0]) begin
			if (adr_i == `OFS_CONTROL_ONE)
				en <= dat_i[`BIT_TRANSCEIVER_EN];
			if (adr_i == `OFS_CLOCK_DIV_SELECT && !en)
				pexp <= dat_i[3:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wl0 <= 1'b0;
			wl1 <= 1'b0;
		end else if (tk && we_i && adr_i == `OFS_CONTROL_ONE) begin
			if (sel_i[1])
				wl0 <= dat_i[`BIT_WORD_LEN0];
			if (sel_i[3])
				wl1 <= dat_i[`BIT_WORD_LEN1];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rx_char_valid_i)
			lrx <= (wl0 && !wl1) ? rx_char_i : {1'b0, rx_char_i[7:0]};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || (tk && we_i && adr_i == `OFS_CLOCK_DIV_SELECT)) begin
			seen <= 1'b0;
			gap <= 9'h000;
		end else if (divided_tick_o) begin
			seen <= 1'b1;
			gap <= 9'h001;
		end else
			gap <= gap + 9'h001;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_req_answer: assert property (tk |=> ack_o != err_o) else $error("request unanswered");
	a_map_ack: assert property (tk && map |=> ack_o) else $error("mapped access not acked");
	a_unmap_err: assert property (tk && !map |=> err_o && !ack_o) else $error("no error");
	a_tdr_resv: assert property (rd && adr_i == `OFS_TRANSMIT_HOLDING |->
		dat_o[31:9] == 23'h0) else $error("transmit reserved bits set");
	a_presc_read: assert property (rd && adr_i == `OFS_CLOCK_DIV_SELECT |->
		dat_o == {28'h0, pexp}) else $error("prescaler readback wrong");
	a_rx_read: assert property (rd && adr_i == `OFS_RECEIVE_HOLDING |->
		dat_o == {23'h0, lrx}) else $error("receive readback wrong");
	a_tick_gap: assert property (divided_tick_o && seen |->
		gap inside {1, 2, 4, 6, 8, 10, 16, 32, 64, 128, 256}) else $error("bad tick ratio");
	a_line_idle: assert property (!en |-> tx_line_o) else $error("line low while disabled");
endmodule
`default_nettype wire

//--- dv/serial_node_model.sv
// Remote serial node: delivers received characters and decodes the line.
`default_nettype none
module serial_node_model #(
	parameter int BIT_CYC = 4
) (
	input  wire logic       clk_i,
	input  wire logic       tx_line_i,
	output logic            rx_char_valid_o,
	output logic [8:0]      rx_char_o,
	output logic            rx_parity_err_o,
	output logic            frame_done_o,
	output logic [8:0]      frame_o
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic send(input logic [8:0] c, input logic pe);
		rx_char_valid_o <= 1'b1;
		rx_char_o <= c;
		rx_parity_err_o <= pe;
		@(posedge clk_i);
		rx_char_valid_o <= 1'b0;
		rx_char_o <= ~c;
		rx_parity_err_o <= ~pe;
	endtask
	initial begin
		rx_char_valid_o = 1'b0;
		rx_char_o = 9'h000;
		rx_parity_err_o = 1'b0;
		frame_done_o = 1'b0;
		frame_o = 9'h000;
		forever begin
			@(negedge tx_line_i);
			repeat (BIT_CYC / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				frame_o[i] <= tx_line_i;
			end
			frame_done_o <= 1'b1;
			@(posedge clk_i);
			frame_done_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- dv/serial_regs_tb.sv
// Self-checking testbench of the serial register block.
`include "serial_regs_cfg.svh"
`default_nettype none
module serial_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [31:0] v; logic [31:0] m; logic e;} exp_t;
	exp_t q[$];
	logic [8:0] fq[$];
	logic clk_i, rst_i, cyc, stb, we, ack, err, rxv, rxp, txl, tick, fdone;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, r;
	logic [8:0] rxc, fr, c;
	int fail_count, n_compared, g;
	int div[16] = '{1, 2, 4, 6, 8, 10, 256, 16, 32, 64, 128, 256, 256, 256, 256, 256};
	serial_regs i_serial_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.err_o(err), .rx_char_valid_i(rxv), .rx_char_i(rxc), .rx_parity_err_i(rxp),
		.tx_line_o(txl), .divided_tick_o(tick));
	serial_node_model i_serial_node_model (.clk_i(clk_i), .tx_line_i(txl),
		.rx_char_valid_o(rxv), .rx_char_o(rxc), .rx_parity_err_o(rxp),
		.frame_done_o(fdone), .frame_o(fr));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] e, input logic [31:0] m);
		q.push_back('{e, m, !(a[1:0] == 2'b00 && a <= 8'h2C && !(a inside {8'h10, 8'h14}))});
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (ack === 1'b1 || err === 1'b1) begin
			chk({31'h0, err}, {31'h0, q[0].e});
			chk(rdat & q[0].m, q[0].v);
			void'(q.pop_front());
		end
		if (fdone === 1'b1)
			chk({23'h0, fr}, {23'h0, fq.pop_front()});
	end
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#500_000;
		fail_count++;
		summarize();
	end
	initial begin
		{cyc, stb, we, adr, wdat} = '0;
		sel = 4'hF;
		rst_i = 1'b1;
		void'($urandom(97330));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, `OFS_STATUS_FLAGS, 0, 32'h0000_0080, 32'h0000_00E1);
		wb(0, `OFS_CLOCK_DIV_SELECT, 0, `RESET_WORD, 32'hFFFF_FFFF);
		wb(0, `OFS_TRANSMIT_HOLDING, 0, `RESET_WORD, 32'hFFFF_FE00);
		wb(0, `OFS_REQUEST_TRIGGER, 0, `RESET_WORD, 32'hFFFF_FFFF);
		wb(0, 8'h10, 0, 0, 0);
		wb(1, 8'h40, 32'hFFFF_FFFF, 0, 0);
		$display("test reset done");
		for (int k = 0; k < 16; k++) begin
			wb(1, `OFS_CLOCK_DIV_SELECT, {28'h0, 4'(k)}, 0, 0);
			@(posedge clk_i iff tick);
			@(posedge clk_i iff tick);
			g = 0;
			do begin
				@(posedge clk_i);
				g++;
			end while (tick !== 1'b1);
			chk(32'(g), 32'(div[k]));
		end
		wb(1, `OFS_CLOCK_DIV_SELECT, 0, 0, 0);
		wb(1, `OFS_BAUD_DIVISOR, 32'h0000_0003, 0, 0);
		wb(1, `OFS_CONTROL_ONE, 32'h0000_0401, 0, 0);
		wb(1, `OFS_CLOCK_DIV_SELECT, 32'h0000_0005, 0, 0);
		wb(0, `OFS_CLOCK_DIV_SELECT, 0, 0, 32'hFFFF_FFFF);
		$display("test prescaler done");
		repeat (3) begin
			c = 9'($urandom);
			do wb(0, `OFS_STATUS_FLAGS, 0, 0, 0); while (r[`BIT_FLAG_TXE] !== 1'b1);
			fq.push_back({1'b1, ^c[6:0], c[6:0]});
			wb(1, `OFS_TRANSMIT_HOLDING, {23'h0, c}, 0, 0);
		end
		do wb(0, `OFS_STATUS_FLAGS, 0, 0, 0); while (r[`BIT_FLAG_TC] !== 1'b1);
		wb(1, `OFS_FLAG_CLEAR, 32'h0000_0040, 0, 0);
		wb(0, `OFS_STATUS_FLAGS, 0, 0, 32'h0000_0040);
		$display("test transmit done");
		for (int k = 0; k < 2; k++) begin
			c = 9'($urandom);
			i_serial_node_model.send(c, k[0]);
			wb(0, `OFS_RECEIVE_HOLDING, 0, {24'h0, c[7:0]}, 32'hFFFF_FFFF);
			wb(0, `OFS_STATUS_FLAGS, 0, {31'h0, k[0]}, 32'h0000_0001);
			wb(1, `OFS_FLAG_CLEAR, 32'h0000_0001, 0, 0);
			wb(0, `OFS_STATUS_FLAGS, 0, 0, 32'h0000_0021);
		end
		$display("test receive done");
		summarize();
	end
endmodule
bind serial_regs serial_regs_checker i_serial_regs_checker (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .rx_char_valid_i(rx_char_valid_i),
	.rx_char_i(rx_char_i), .tx_line_o(tx_line_o), .divided_tick_o(divided_tick_o));
`default_nettype wire
